//--- design/sdram_seq_defines.vh
// Notes on behaviour
// - Mode register set puts the mode-data value onto address lines.
// - Command 0x80808105 runs mode register set pattern at locations 5 to 8.
// - Command 0x80808130 runs refresh pattern, as many refresh cycles as the loop count (eight at init).
// - Timer issues a burst of four auto-refreshes every 62.4 microseconds.
// - All 2048 rows refreshed within 31.95 milliseconds.
// - Address split into 11 row bits and 8 column bits on shared lines.
// - Row and column strobes come from general lines one and two.
// - Address bit 10 from general line zero: address bit or fixed level.
// - Write enable comes from general line three.
`ifndef SDRAM_SEQ_DEFINES_VH
`define SDRAM_SEQ_DEFINES_VH
// Register offsets (byte addresses)
`define OFS_MODE_DATA   8'h00
`define OFS_MACH_CMD    8'h04
`define OFS_MACH_MODE   8'h08
`define OFS_PRESCALER   8'h0C
`define OFS_STATUS      8'h10
// Command words
`define CMD_MRS         32'h80808105
`define CMD_REFRESH     32'h80808130
// Machine mode register fields
`define LOOP_LSB        0
`define LOOP_MSB        3
`define LOOP_RESET      4'h4
`define LOOP_NORMAL     4'h4
`define LOOP_INIT       4'h8
`define MODE_DATA_RESET 12'h000
`define TMR_EN_BIT      4
// Pattern memory locations of mode register set
`define MRS_FIRST       3'h5
`define MRS_LAST        4'h8
// Timing: refresh interval in ns, clock period in ns
`define REF_INTERVAL_NS 62400
`define CLK_PERIOD_NS   8
`define REF_CYCLES      (`REF_INTERVAL_NS / `CLK_PERIOD_NS)
// Command gap after each auto-refresh, cycles
`define REF_GAP         4'h7
// SDRAM command encodings {ras_n, cas_n, we_n}
`define SD_NOP          3'h7
`define SD_REFRESH      3'h1
`define SD_MRS          3'h0
`define SD_PRECHARGE    3'h2
`endif

//--- design/refresh_timer.v
`timescale 1ns/1ps
`include "sdram_seq_defines.vh"
// Periodic refresh request generator
module refresh_timer #(
    parameter PERIOD = `REF_CYCLES
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // Control
    input  wire        enable,
    // One-cycle request
    output reg         tick_r
);
    reg [19:0] count_r;

    // Free-running down counter; restarts whenever disabled
    always @(posedge ref_clk)
    begin
        if (sys_rst || !enable)
        begin
            count_r <= PERIOD[19:0] - 20'h00001;
            tick_r  <= 1'b0;
        end
        else if (count_r == 20'h00000)
        begin
            count_r <= PERIOD[19:0] - 20'h00001;
            tick_r  <= 1'b1;
        end
        else
        begin
            count_r <= count_r - 20'h00001;
            tick_r  <= 1'b0;
        end
    end
endmodule // refresh_timer

//--- design/sdram_init_refresh_sequencer.v
`timescale 1ns/1ps
`include "sdram_seq_defines.vh"
// SDRAM mode-set and refresh sequencer with register port
module sdram_init_refresh_sequencer #(
    parameter REF_PERIOD = `REF_CYCLES,
    parameter ROW_BITS   = 11,
    parameter COL_BITS   = 8
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata_r,
    // SDRAM pins
    output reg         sd_cs_n_r,
    output reg         general_line_zero_r,
    output reg         general_line_one_r,
    output reg         general_line_two_r,
    output reg         general_line_three_r,
    output reg  [9:0]  sd_addr_r,
    // Status
    output wire        sdram_ready
);
    // One-hot states. The controller only issues what the two command
    // words and the timer ask for; normal reads and writes belong to
    // another block, which must wait for sdram_ready.
    localparam S_IDLE = 4'b0001;
    localparam S_MRS  = 4'b0010;
    localparam S_REF  = 4'b0100;
    localparam S_GAP  = 4'b1000;

    // Software-visible registers; the prescaler is stored for readback
    // only, since the period parameter already fixes the tick spacing
    reg [11:0] mode_data_register_r;
    reg [31:0] machine_b_mode_register_r;
    reg [15:0] refresh_timer_prescaler_r;
    // Sequencer progress and burst bookkeeping
    reg        mrs_done_r;
    reg        init_ref_done_r;
    reg [3:0]  state_r;
    reg [3:0]  step_r;
    reg [3:0]  beats_r;
    reg [3:0]  gap_r;
    reg        pend_r;
    wire       tick;
    wire [3:0] loop_count;
    wire       cmd_wr;
    wire       cmd_mrs_hit;
    wire       cmd_ref_hit;

    assign loop_count = machine_b_mode_register_r[`LOOP_MSB:`LOOP_LSB];

    // Command port decode. Only the two known words start anything;
    // every other word written to the command offset is dropped silently.
    assign cmd_wr      = reg_wr && (reg_addr == `OFS_MACH_CMD);
    assign cmd_mrs_hit = cmd_wr && (reg_wdata == `CMD_MRS);
    assign cmd_ref_hit = cmd_wr && (reg_wdata == `CMD_REFRESH);
    // Ready only after mode set, initial refresh and loop count back at four
    assign sdram_ready = mrs_done_r && init_ref_done_r &&
                         (loop_count == `LOOP_NORMAL);

    // Timer restarts from its full period whenever software turns it off
    refresh_timer #(
        .PERIOD (REF_PERIOD)
    ) u_timer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .enable  (machine_b_mode_register_r[`TMR_EN_BIT]),
        .tick_r  (tick)
    );

    // Register writes
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mode_data_register_r      <= `MODE_DATA_RESET;
            machine_b_mode_register_r <= {28'h0000000, `LOOP_RESET};
            refresh_timer_prescaler_r <= 16'h0000;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_MODE_DATA: mode_data_register_r <= reg_wdata[11:0];
                `OFS_MACH_MODE: machine_b_mode_register_r <= reg_wdata;
                `OFS_PRESCALER: refresh_timer_prescaler_r <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always @(posedge ref_clk)
    begin
        if (sys_rst)
            reg_rdata_r <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `OFS_MODE_DATA: reg_rdata_r <= {20'h00000,
                                                mode_data_register_r};
                `OFS_MACH_MODE: reg_rdata_r <= machine_b_mode_register_r;
                `OFS_PRESCALER: reg_rdata_r <= {16'h0000,
                                                refresh_timer_prescaler_r};
                `OFS_STATUS:    reg_rdata_r <= {24'h000000, state_r,
                                                1'b0, sdram_ready,
                                                init_ref_done_r, mrs_done_r};
                default:        reg_rdata_r <= 32'h00000000;
            endcase
        end
        else
            reg_rdata_r <= 32'h00000000;
    end

    // Sequencer: commands from the port, periodic refresh from the timer.
    // A tick that arrives while busy is held so no refresh burst is lost.
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_r              <= S_IDLE;
            step_r               <= 4'h0;
            beats_r              <= 4'h0;
            gap_r                <= 4'h0;
            pend_r               <= 1'b0;
            mrs_done_r           <= 1'b0;
            init_ref_done_r      <= 1'b0;
            sd_cs_n_r            <= 1'b1;
            general_line_zero_r  <= 1'b0;
            general_line_one_r   <= 1'b1;
            general_line_two_r   <= 1'b1;
            general_line_three_r <= 1'b1;
            sd_addr_r            <= 10'h000;
        end
        else
        begin
            // Default idle bus: NOP with chip deselected
            sd_cs_n_r            <= 1'b1;
            general_line_one_r   <= 1'b1;
            general_line_two_r   <= 1'b1;
            general_line_three_r <= 1'b1;
            // Ticks before mode set are dropped: refreshing an unset chip
            // buys nothing and would disturb the init order
            if (tick && mrs_done_r)
                pend_r <= 1'b1;
            case (state_r)
                // Idle: mode set wins over refresh; a pending tick
                // waits behind an explicit command rather than merging
                S_IDLE:
                begin
                    if (cmd_mrs_hit)
                    begin
                        state_r <= S_MRS;
                        step_r  <= {1'b0, `MRS_FIRST};
                    end
                    else if (cmd_ref_hit || pend_r)
                    begin
                        state_r <= S_REF;
                        beats_r <= loop_count;
                        // A tick in this very cycle re-arms the request,
                        // so the set wins over the clear
                        if (!cmd_ref_hit)
                            pend_r <= tick && mrs_done_r;
                        else if (loop_count == `LOOP_INIT)
                            init_ref_done_r <= 1'b1;
                    end
                end
                // Mode set walks the pattern steps one per cycle
                S_MRS:
                begin
                    // Steps 5..8: precharge all, then MRS, then idle
                    if (step_r == {1'b0, `MRS_FIRST})
                    begin
                        sd_cs_n_r            <= 1'b0;
                        general_line_zero_r  <= 1'b1; // all banks
                        {general_line_one_r, general_line_two_r,
                         general_line_three_r} <= `SD_PRECHARGE;
                    end
                    else if (step_r == `MRS_LAST - 4'h1)
                    begin
                        sd_cs_n_r <= 1'b0;
                        // Mode value carries burst and CAS latency
                        // fields on the row lines, top bit on line zero
                        sd_addr_r <=
                            mode_data_register_r[ROW_BITS-2:0];
                        general_line_zero_r <=
                            mode_data_register_r[ROW_BITS-1];
                        {general_line_one_r, general_line_two_r,
                         general_line_three_r} <= `SD_MRS;
                    end
                    if (step_r == `MRS_LAST)
                    begin
                        state_r    <= S_IDLE;
                        mrs_done_r <= 1'b1;
                    end
                    step_r <= step_r + 4'h1;
                end
                // One auto-refresh beat, then a fixed recovery gap
                S_REF:
                begin
                    sd_cs_n_r <= 1'b0;
                    {general_line_one_r, general_line_two_r,
                     general_line_three_r} <= `SD_REFRESH;
                    beats_r <= beats_r - 4'h1;
                    gap_r   <= `REF_GAP;
                    state_r <= S_GAP;
                end
                // Gap keeps beats eight cycles apart; no command may cut in
                S_GAP:
                begin
                    gap_r <= gap_r - 4'h1;
                    if (gap_r == 4'h1)
                        state_r <= (beats_r == 4'h0) ? S_IDLE : S_REF;
                end
                // Unreachable with one-hot coding; recover to idle
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // sdram_init_refresh_sequencer

//--- sim/sdram_seq_sva.sv
`timescale 1ns/1ps
`include "sdram_seq_defines.vh"
// Port-level checks of the sequencer pins and register port
module sdram_seq_sva (
    input wire        ref_clk,
    input wire        sys_rst,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata_r,
    input wire        sd_cs_n_r,
    input wire        general_line_zero_r,
    input wire        general_line_one_r,
    input wire        general_line_two_r,
    input wire        general_line_three_r,
    input wire [9:0]  sd_addr_r,
    input wire        sdram_ready
);
    reg  [11:0] mode_r;
    reg         set_done_r;
    wire        cmd_w = reg_wr && reg_addr == `OFS_MACH_CMD;
    wire [3:0]  pins  = {sd_cs_n_r, general_line_one_r,
                         general_line_two_r, general_line_three_r};
    // Shadow of mode data, so the address pins can be judged at the set
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mode_r     <= `MODE_DATA_RESET;
            set_done_r <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `OFS_MODE_DATA)
                mode_r <= reg_wdata[11:0];
            if (pins == 4'h0)
                set_done_r <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_mrs_precharge: assert property (
        cmd_w && reg_wdata == `CMD_MRS |-> ##2
        pins == {1'b0, `SD_PRECHARGE} && general_line_zero_r)
        else $error("no precharge-all before mode set");
    a_mrs_set: assert property (
        cmd_w && reg_wdata == `CMD_MRS |-> ##4 pins == 4'h0)
        else $error("mode set command late or missing");
    a_mode_on_addr: assert property (
        pins == 4'h0 |-> {general_line_zero_r, sd_addr_r} == mode_r[10:0])
        else $error("mode value not on address lines");
    a_refresh_start: assert property (
        cmd_w && reg_wdata == `CMD_REFRESH |-> ##2
        pins == {1'b0, `SD_REFRESH})
        else $error("refresh command did not start");
    a_refresh_gap: assert property (
        pins == {1'b0, `SD_REFRESH} |=> sd_cs_n_r [*7])
        else $error("refresh spacing wrong");
    a_deselect_nop: assert property (
        sd_cs_n_r |-> pins[2:0] == `SD_NOP)
        else $error("strobes active while deselected");
    a_no_early_ref: assert property (
        pins == {1'b0, `SD_REFRESH} |-> set_done_r)
        else $error("refresh before mode set");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata_r == 32'h0)
        else $error("read data outside read answer");
    c_mrs: cover property (pins == 4'h0);
    c_ref: cover property (pins == {1'b0, `SD_REFRESH});
    c_read: cover property (reg_rd ##1 reg_rdata_r != 32'h0);
endmodule // sdram_seq_sva

bind sdram_init_refresh_sequencer sdram_seq_sva chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .sd_cs_n_r(sd_cs_n_r),
    .general_line_zero_r(general_line_zero_r),
    .general_line_one_r(general_line_one_r),
    .general_line_two_r(general_line_two_r),
    .general_line_three_r(general_line_three_r),
    .sd_addr_r(sd_addr_r), .sdram_ready(sdram_ready));

//--- sim/sdram_chip_model.sv
`timescale 1ns/1ps
`include "sdram_seq_defines.vh"
// Single SDRAM chip; refuses a mode set not preceded by precharge-all
module sdram_chip_model (
    input wire        ref_clk,
    input wire        cs_n,
    input wire        ras_n,
    input wire        cas_n,
    input wire        we_n,
    input wire        a10,
    input wire [9:0]  addr,
    output reg [10:0] mode_r,
    output reg        set_seen_r,
    output reg        pre_seen_r,
    output integer    ref_cnt
);
    wire [2:0] cmd = {ras_n, cas_n, we_n};
    initial
    begin
        mode_r     = 11'h000;
        set_seen_r = 1'b0;
        pre_seen_r = 1'b0;
        ref_cnt    = 0;
    end
    // Commands count only while selected
    always @(posedge ref_clk)
    begin
        if (!cs_n && cmd == `SD_PRECHARGE && a10)
            pre_seen_r <= 1'b1;
        if (!cs_n && cmd == `SD_MRS && pre_seen_r)
        begin
            mode_r     <= {a10, addr};
            set_seen_r <= 1'b1;
        end
        if (!cs_n && cmd == `SD_REFRESH)
            ref_cnt <= ref_cnt + 1;
    end
endmodule // sdram_chip_model

//--- sim/tb.sv
`timescale 1ns/1ps
`include "sdram_seq_defines.vh"
// Self-checking bench for the init and refresh sequencer
module tb;
    localparam PER = 60; // Short refresh period keeps the run brief
    reg         ref_clk, sys_rst, reg_wr, reg_rd;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata, d;
    reg  [71:0] rows [0:5];
    wire [31:0] rdata;
    wire [9:0]  sd_addr;
    wire [10:0] mode;
    wire        cs_n, l0, l1, l2, l3, ready, set_seen, pre_seen;
    integer     ref_cnt, errors, num_checks, i, n;
    sdram_init_refresh_sequencer #(.REF_PERIOD(PER)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(rdata), .sd_cs_n_r(cs_n),
        .general_line_zero_r(l0), .general_line_one_r(l1),
        .general_line_two_r(l2), .general_line_three_r(l3),
        .sd_addr_r(sd_addr), .sdram_ready(ready));
    sdram_chip_model mem (
        .ref_clk(ref_clk), .cs_n(cs_n), .ras_n(l1), .cas_n(l2),
        .we_n(l3), .a10(l0), .addr(sd_addr), .mode_r(mode),
        .set_seen_r(set_seen), .pre_seen_r(pre_seen), .ref_cnt(ref_cnt));
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task wrap_up;
    begin
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [31:0] v);
    begin
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
    endtask
    // Read answer stands only in the cycle after the strobe
    task rd(input [7:0] a);
    begin
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    end
    endtask
    // Bounded wait for the chip model to see n refreshes
    task wait_ref(input integer want);
        integer k;
    begin
        for (k = 0; k < 300 && ref_cnt < want; k = k + 1)
            @(posedge ref_clk) #1;
        if (ref_cnt < want)
        begin
            errors = errors + 1;
            wrap_up;
        end
    end
    endtask
    initial
    begin
        errors = 0; num_checks = 0; sys_rst = 1'b1; reg_wr = 1'b0;
        reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
        rows[0] = {8'h00, 32'hFFFFFFFF, 32'h00000FFF};
        rows[1] = {8'h00, 32'h00000048, 32'h00000048};
        rows[2] = {8'h0C, 32'h0001ABCD, 32'h0000ABCD};
        rows[3] = {8'h08, 32'h00000003, 32'h00000003};
        rows[4] = {8'h04, 32'h00000000, 32'h00000000};
        rows[5] = {8'h20, 32'h12345678, 32'h00000000};
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 chk({30'h0, cs_n, ready}, 32'h2);
        rd(`OFS_MACH_MODE); chk(d, 32'h4);
        rd(`OFS_MODE_DATA); chk(d, 32'h0);
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(rows[i][71:64], rows[i][63:32]);
            rd(rows[i][71:64]); chk(d, rows[i][31:0]);
        end
        wr(`OFS_MACH_MODE, 32'h14);
        repeat (2 * PER) @(posedge ref_clk);
        chk(ref_cnt, 0);
        wr(`OFS_MACH_CMD, 32'h80808106);
        repeat (10) @(posedge ref_clk);
        chk({31'h0, pre_seen}, 32'h0);
        wr(`OFS_MACH_MODE, 32'h04);
        wr(`OFS_MODE_DATA, 32'h48);
        wr(`OFS_MACH_CMD, `CMD_MRS);
        repeat (8) @(posedge ref_clk);
        chk({20'h0, set_seen, mode}, 32'h848);
        wr(`OFS_MACH_MODE, 32'h08);
        wr(`OFS_MACH_CMD, `CMD_REFRESH);
        wait_ref(8);
        repeat (20) @(posedge ref_clk);
        chk(ref_cnt, 8);
        rd(`OFS_STATUS); chk(d & 32'h2, 32'h2);
        wr(`OFS_MACH_MODE, 32'h14);
        #1 chk({31'h0, ready}, 32'h1);
        wait_ref(9);
        n = ref_cnt;
        repeat (PER - 4) @(posedge ref_clk);
        chk(ref_cnt - n, 3);
        wait_ref(n + 4);
        // Reset in mid-run: back to power-up state, no periodic refresh
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 chk({30'h0, cs_n, ready}, 32'h2);
        n = ref_cnt;
        rd(`OFS_MACH_MODE); chk(d, 32'h4);
        repeat (2 * PER) @(posedge ref_clk);
        chk(ref_cnt - n, 0);
        wrap_up;
    end
endmodule // tb
